// File: hdl/gpp_pkg.sv
/*
 * gpp_pkg: shared constants of the general-purpose pin block: register
 * offsets, field positions, reset values and time-base divider masks.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package gpp_pkg;
	// ***********************************************************
	// sizes
	// ***********************************************************
	localparam int NUM_IO = 5;
	localparam int NUM_ANA = 4;
	localparam int NUM_SPECIAL = 4;
	localparam int CNT_W = 7;
	localparam int TB_W = 2;
	localparam int RB_W = 2;
	localparam int MEAS_W = 8;
	localparam int PRE_W = 10;
	localparam int ADDR_W = 6;
	localparam int CLK_PERIOD_NS = 100;

	// ***********************************************************
	// register byte offsets
	// ***********************************************************
	localparam logic [5:0] OFS_IO_CFG = 6'h00;
	localparam logic [5:0] OFS_IO_TB = 6'h04;
	localparam logic [5:0] OFS_ANA_CFG = 6'h08;
	localparam logic [5:0] OFS_IO_RB = 6'h0C;
	localparam logic [5:0] OFS_ANA_RB = 6'h10;
	localparam logic [5:0] OFS_THR = 6'h14;
	localparam logic [5:0] OFS_PWM0 = 6'h18;

	// ***********************************************************
	// field positions
	// ***********************************************************
	localparam int POS_DIR = 0;
	localparam int POS_FMT = 8;
	localparam int POS_SRC = 16;
	localparam int POS_LVL = 24;
	localparam int POS_ANA_TB = 24;
	localparam int POS_ANA_LVL = 16;
	localparam int POS_LL_LC = 0;
	localparam int POS_LL_HC = 8;
	localparam int POS_LH_LC = 16;
	localparam int POS_LH_HC = 24;
	localparam int POS_THR1 = 0;
	localparam int POS_THR2 = 4;
	localparam int POS_THR3 = 8;

	// ***********************************************************
	// writable masks and reset values
	// ***********************************************************
	localparam logic [31:0] MSK_IO_CFG = 32'h1F0F1F1F;
	localparam logic [31:0] MSK_IO_TB = 32'h000003FF;
	localparam logic [31:0] MSK_ANA_CFG = 32'hFF0F0F0F;
	localparam logic [31:0] MSK_THR = 32'h00000FFF;
	localparam logic [31:0] MSK_PWM = 32'h7F7F7F7F;
	localparam logic [31:0] RST_THR = 32'h00000642;
	localparam logic [31:0] RST_ZERO = 32'h00000000;

	// ***********************************************************
	// time base: tick when prescaler low bits are all ones
	// ***********************************************************
	localparam logic [PRE_W-1:0] TB_MASK0 = 10'h07F; // 128 clocks
	localparam logic [PRE_W-1:0] TB_MASK1 = 10'h0FF; // 256 clocks
	localparam logic [PRE_W-1:0] TB_MASK2 = 10'h1FF; // 512 clocks
	localparam logic [PRE_W-1:0] TB_MASK3 = 10'h3FF; // 1024 clocks
	localparam logic [MEAS_W-1:0] MEAS_MAX = 8'hFF;

	// bus answer states
	typedef enum logic [1:0] {
		GPP_IDLE = 2'b01,
		GPP_ACK = 2'b10
	} gpp_bus_e;
endpackage

// File: hdl/gpp_top.sv
/*
 * gpp_top: five io-supply pins (static or pwm out, pwm decode, special
 * outputs on the first four) and four analog-supply pins (static out,
 * static or pwm decode), with an Avalon-MM register slave.
 * Assumes pin inputs are synchronous to clk_i and that the pad ring
 * combines out/oe into push-pull drivers.
 */
`timescale 1ns/1ps
// Function
// - five io pins, each own direction bit
// - io format bit selects static or pwm
// - four io pins route special outputs
// - io output drives level bit, push-pull
// - special output ignores the level bit
// - io readback reports pin level in static format, decoded code in pwm format
// - reset makes every pin an input
// - two seven-bit count pairs, shared time base
// - low then high phase, counts times base
// - time base setting 3 is 1024 clocks
// - every pwm period with a nonzero low count begins low
// - level change applies at next period start
// - pwm decode uses pin time base, four codes
// - decoded level correct within two periods
// - four analog pins, each own direction
// - analog format only affects input decoding
// - analog output drives level bit, push-pull
// - analog readback reports pin level in static format, decoded code in pwm format
module gpp_top #(
	parameter int N_IO = 5,
	parameter int N_ANA = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic fault_i,
	input wire logic status_i,
	input wire logic occ_a_i,
	input wire logic occ_b_i,
	input wire logic [N_IO-1:0] io_pin_i,
	output logic [N_IO-1:0] io_pin_o,
	output logic [N_IO-1:0] io_pin_oe_o,
	input wire logic [N_ANA-1:0] ana_pin_i,
	output logic [N_ANA-1:0] ana_pin_o,
	output logic [N_ANA-1:0] ana_pin_oe_o
);
	localparam int NP = N_IO + N_ANA;

	// field layout holds exactly five io and at most four analog pins
	if (N_IO != gpp_pkg::NUM_IO || N_ANA < 1 || N_ANA > gpp_pkg::NUM_ANA)
		$error("gpp_top: pin counts not supported");

	// ***********************************************************
	// helper functions
	// ***********************************************************
	function automatic logic tb_hit(input logic [1:0] sel,
			input logic [gpp_pkg::PRE_W-1:0] p);
		logic [gpp_pkg::PRE_W-1:0] m;
		case (sel)
			2'h0: m = gpp_pkg::TB_MASK0;
			2'h1: m = gpp_pkg::TB_MASK1;
			2'h2: m = gpp_pkg::TB_MASK2;
			default: m = gpp_pkg::TB_MASK3;
		endcase
		return (p & m) == m;
	endfunction

	// duty in eighths compared against three thresholds
	function automatic logic [1:0] classify(input logic [7:0] h,
			input logic [7:0] l, input logic [11:0] thr);
		logic [12:0] d;
		logic [12:0] s;
		logic [1:0] c;
		d = {2'h0, h, 3'h0};
		s = {4'h0, 9'({1'b0, h} + {1'b0, l})};
		c = 2'h0;
		for (int k = 0; k < 3; k++) begin
			if (d >= 13'(thr[4*k +: 4] * s) && c < 2'h3) begin
				c = c + 2'h1;
			end
		end
		return c;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be,
			input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r & msk;
	endfunction

	// ***********************************************************
	// register bus slave
	// ***********************************************************
	gpp_pkg::gpp_bus_e st_q;
	logic [31:0] io_cfg_q, io_tb_q, ana_cfg_q, thr_q;
	logic [31:0] pwm_q [N_IO];
	logic [31:0] rdata_d, rdata_q;
	logic wait_q;
	logic [1:0] rb_q [NP];
	logic [31:0] io_rb_w, ana_rb_w;
	logic wr_go;

	// write takes effect only at the edge where waitrequest is low
	assign wr_go = (st_q == gpp_pkg::GPP_ACK) && avs_write_i;

	always_comb begin
		io_rb_w = 32'h0;
		ana_rb_w = 32'h0;
		for (int i = 0; i < N_IO; i++) begin
			io_rb_w[2*i +: 2] = rb_q[i];
		end
		for (int i = 0; i < N_ANA; i++) begin
			ana_rb_w[2*i +: 2] = rb_q[N_IO+i];
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0;
		case (avs_address_i)
			gpp_pkg::OFS_IO_CFG: rdata_d = io_cfg_q;
			gpp_pkg::OFS_IO_TB: rdata_d = io_tb_q;
			gpp_pkg::OFS_ANA_CFG: rdata_d = ana_cfg_q;
			gpp_pkg::OFS_IO_RB: rdata_d = io_rb_w;
			gpp_pkg::OFS_ANA_RB: rdata_d = ana_rb_w;
			gpp_pkg::OFS_THR: rdata_d = thr_q;
			default: begin
				for (int i = 0; i < N_IO; i++) begin
					if (avs_address_i == 6'(gpp_pkg::OFS_PWM0 + 4*i)) begin
						rdata_d = pwm_q[i];
					end
				end
			end
		endcase
	end

	// one wait cycle, then a single low cycle of waitrequest
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= gpp_pkg::GPP_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0;
		end else begin
			case (st_q)
				gpp_pkg::GPP_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						st_q <= gpp_pkg::GPP_ACK;
						wait_q <= 1'b0;
						rdata_q <= avs_read_i ? rdata_d : 32'h0;
					end
				end
				gpp_pkg::GPP_ACK: begin
					st_q <= gpp_pkg::GPP_IDLE;
					wait_q <= 1'b1;
				end
				default: begin
					st_q <= gpp_pkg::GPP_IDLE;
					wait_q <= 1'b1;
				end
			endcase
		end
	end
	assign avs_waitrequest_o = wait_q;
	assign avs_readdata_o = rdata_q;

	// configuration storage; reset leaves every direction bit at input
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			io_cfg_q <= gpp_pkg::RST_ZERO;
			io_tb_q <= gpp_pkg::RST_ZERO;
			ana_cfg_q <= gpp_pkg::RST_ZERO;
			thr_q <= gpp_pkg::RST_THR;
			for (int i = 0; i < N_IO; i++) begin
				pwm_q[i] <= gpp_pkg::RST_ZERO;
			end
		end else if (wr_go) begin
			case (avs_address_i)
				gpp_pkg::OFS_IO_CFG: io_cfg_q <= merge(io_cfg_q,
					avs_writedata_i, avs_byteenable_i, gpp_pkg::MSK_IO_CFG);
				gpp_pkg::OFS_IO_TB: io_tb_q <= merge(io_tb_q,
					avs_writedata_i, avs_byteenable_i, gpp_pkg::MSK_IO_TB);
				gpp_pkg::OFS_ANA_CFG: ana_cfg_q <= merge(ana_cfg_q,
					avs_writedata_i, avs_byteenable_i, gpp_pkg::MSK_ANA_CFG);
				gpp_pkg::OFS_THR: thr_q <= merge(thr_q,
					avs_writedata_i, avs_byteenable_i, gpp_pkg::MSK_THR);
				default: begin
					for (int i = 0; i < N_IO; i++) begin
						if (avs_address_i == 6'(gpp_pkg::OFS_PWM0 + 4*i)) begin
							pwm_q[i] <= merge(pwm_q[i], avs_writedata_i,
								avs_byteenable_i, gpp_pkg::MSK_PWM);
						end
					end
				end
			endcase
		end
	end

	// ***********************************************************
	// shared time-base prescaler
	// ***********************************************************
	logic [gpp_pkg::PRE_W-1:0] presc_q;
	logic [NP-1:0] tick_w, fmt_w, pin_w;
	logic [1:0] tb_w [NP];

	// one free-running divider serves every pin; the trade is that a
	// new time base lines up with the divider, not with the write
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 10'h001;
		end
	end

	always_comb begin
		for (int i = 0; i < N_IO; i++) begin
			fmt_w[i] = io_cfg_q[gpp_pkg::POS_FMT+i];
			tb_w[i] = io_tb_q[2*i +: 2];
			pin_w[i] = io_pin_i[i];
		end
		for (int i = 0; i < N_ANA; i++) begin
			fmt_w[N_IO+i] = ana_cfg_q[gpp_pkg::POS_FMT+i];
			tb_w[N_IO+i] = ana_cfg_q[gpp_pkg::POS_ANA_TB+2*i +: 2];
			pin_w[N_IO+i] = ana_pin_i[i];
		end
		for (int i = 0; i < NP; i++) begin
			tick_w[i] = tb_hit(tb_w[i], presc_q);
		end
	end

	// ***********************************************************
	// pwm generators, io pins only
	// ***********************************************************
	logic [7:0] pos_q [N_IO];
	logic [N_IO-1:0] sel_q, pend_w, pwm_w;

	for (genvar g = 0; g < N_IO; g++) begin : g_pwm
		logic [6:0] lc, hc;
		logic [7:0] per;
		// active pair follows the latched level, not the live bit
		assign lc = sel_q[g] ? pwm_q[g][gpp_pkg::POS_LH_LC +: 7] :
			pwm_q[g][gpp_pkg::POS_LL_LC +: 7];
		assign hc = sel_q[g] ? pwm_q[g][gpp_pkg::POS_LH_HC +: 7] :
			pwm_q[g][gpp_pkg::POS_LL_HC +: 7];
		assign per = {1'b0, lc} + {1'b0, hc};
		assign pend_w[g] = tick_w[g] && (pos_q[g] + 8'h01 >= per);
		assign pwm_w[g] = pos_q[g] >= {1'b0, lc};

		// pair switch happens only where a new period starts
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				pos_q[g] <= 8'h00;
				sel_q[g] <= 1'b0;
			end else if (!fmt_w[g] || pend_w[g]) begin
				pos_q[g] <= 8'h00;
				sel_q[g] <= io_cfg_q[gpp_pkg::POS_LVL+g];
			end else if (tick_w[g]) begin
				pos_q[g] <= pos_q[g] + 8'h01;
			end
		end
	end

	// ***********************************************************
	// pin drivers
	// ***********************************************************
	logic [N_IO-1:0] io_drv_d;
	logic [gpp_pkg::NUM_SPECIAL-1:0] spec_w;
	assign spec_w = {occ_b_i, occ_a_i, status_i, fault_i};

	// special source wins over format and level
	always_comb begin
		for (int i = 0; i < N_IO; i++) begin
			io_drv_d[i] = fmt_w[i] ? pwm_w[i] :
				io_cfg_q[gpp_pkg::POS_LVL+i];
			if (i < gpp_pkg::NUM_SPECIAL &&
					io_cfg_q[gpp_pkg::POS_SRC+i]) begin
				io_drv_d[i] = spec_w[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			io_pin_oe_o <= '0;
			io_pin_o <= '0;
			ana_pin_oe_o <= '0;
			ana_pin_o <= '0;
		end else begin
			io_pin_oe_o <= io_cfg_q[gpp_pkg::POS_DIR +: N_IO];
			io_pin_o <= io_drv_d;
			ana_pin_oe_o <= ana_cfg_q[gpp_pkg::POS_DIR +: N_ANA];
			ana_pin_o <= ana_cfg_q[gpp_pkg::POS_ANA_LVL +: N_ANA];
		end
	end

	// ***********************************************************
	// readback and pwm decoders, all nine pins
	// ***********************************************************
	logic [NP-1:0] in_q, samp_q, dend_w;
	logic [7:0] lcnt_q [NP];
	logic [7:0] hcnt_q [NP];

	for (genvar g = 0; g < NP; g++) begin : g_dec
		logic [1:0] code;
		// period ends at a falling edge seen on the time-base grid;
		// a source faster than the grid aliases and decodes wrongly
		assign dend_w[g] = tick_w[g] && samp_q[g] && !in_q[g];
		assign code = (lcnt_q[g] == gpp_pkg::MEAS_MAX) ? 2'h0 :
			(hcnt_q[g] == gpp_pkg::MEAS_MAX) ? 2'h3 :
			classify(hcnt_q[g], lcnt_q[g], thr_q[11:0]);

		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				in_q[g] <= 1'b0;
				samp_q[g] <= 1'b0;
				lcnt_q[g] <= 8'h00;
				hcnt_q[g] <= 8'h00;
				rb_q[g] <= 2'h0;
			end else begin
				in_q[g] <= pin_w[g];
				if (tick_w[g]) begin
					samp_q[g] <= in_q[g];
				end
				if (!fmt_w[g]) begin
					rb_q[g] <= {1'b0, in_q[g]};
					lcnt_q[g] <= 8'h00;
					hcnt_q[g] <= 8'h00;
				end else if (dend_w[g]) begin
					rb_q[g] <= code;
					lcnt_q[g] <= 8'h01;
					hcnt_q[g] <= 8'h00;
				end else if (tick_w[g]) begin
					if (!in_q[g] && lcnt_q[g] != gpp_pkg::MEAS_MAX) begin
						lcnt_q[g] <= lcnt_q[g] + 8'h01;
					end
					if (in_q[g] && hcnt_q[g] != gpp_pkg::MEAS_MAX) begin
						hcnt_q[g] <= hcnt_q[g] + 8'h01;
					end
					// a stuck pin saturates into code 0 or 3
					if (lcnt_q[g] == gpp_pkg::MEAS_MAX ||
							hcnt_q[g] == gpp_pkg::MEAS_MAX) begin
						rb_q[g] <= code;
					end
				end
			end
		end
	end

	// ***********************************************************
	// assertions
	// ***********************************************************
	property p_reset_inputs;
		@(posedge clk_i) !rst_n_i |=> (io_pin_oe_o == '0) &&
			(ana_pin_oe_o == '0);
	endproperty
	a_reset_inputs: assert property (p_reset_inputs)
		else $error("pin enabled right after reset");

	property p_dir_write;
		@(posedge clk_i) disable iff (!rst_n_i)
		(wr_go && avs_address_i == gpp_pkg::OFS_IO_CFG &&
			avs_byteenable_i[0]) |-> ##2
			io_pin_oe_o == $past(avs_writedata_i[N_IO-1:0], 2);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("io direction does not follow write");

	property p_special;
		@(posedge clk_i) disable iff (!rst_n_i)
		io_cfg_q[gpp_pkg::POS_SRC] |=> io_pin_o[0] == $past(fault_i);
	endproperty
	a_special: assert property (p_special)
		else $error("special source not driven on pin 0");

	property p_static_lvl;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!fmt_w[4] && io_cfg_q[gpp_pkg::POS_LVL+4]) |=> io_pin_o[4];
	endproperty
	a_static_lvl: assert property (p_static_lvl)
		else $error("static level not driven");

	property p_start_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		(fmt_w[0] && pend_w[0] && pwm_q[0][gpp_pkg::POS_LL_LC +: 7] != 7'h0
			&& pwm_q[0][gpp_pkg::POS_LH_LC +: 7] != 7'h0)
			|=> !pwm_w[0] ##1 !io_pin_o[0] || io_cfg_q[gpp_pkg::POS_SRC];
	endproperty
	a_start_low: assert property (p_start_low)
		else $error("pwm period did not start low");

	property p_switch_edge;
		@(posedge clk_i) disable iff (!rst_n_i)
		(fmt_w[0] && $past(fmt_w[0]) && $changed(sel_q[0])) |->
			$past(pend_w[0]);
	endproperty
	a_switch_edge: assert property (p_switch_edge)
		else $error("pair switched inside a period");

	// clocks between pin-0 ticks; restarts whenever the base is not 3,
	// so only a full gap on the slowest base is ever judged
	logic [10:0] tgap_q;
	logic tseen_q;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || tb_w[0] != 2'h3) begin
			tgap_q <= 11'h000;
			tseen_q <= 1'b0;
		end else if (tick_w[0]) begin
			tgap_q <= 11'h000;
			tseen_q <= 1'b1;
		end else begin
			tgap_q <= tgap_q + 11'h001;
		end
	end

	property p_tb1024;
		@(posedge clk_i) disable iff (!rst_n_i)
		(tb_w[0] == 2'h3 && tick_w[0] && tseen_q) |->
			tgap_q == {1'b0, gpp_pkg::TB_MASK3};
	endproperty
	a_tb1024: assert property (p_tb1024)
		else $error("time base 3 not 1024 clocks");

	property p_dec_update;
		@(posedge clk_i) disable iff (!rst_n_i)
		(fmt_w[5] && dend_w[5] && lcnt_q[5] != gpp_pkg::MEAS_MAX &&
			hcnt_q[5] != gpp_pkg::MEAS_MAX) |=>
			rb_q[5] == $past(classify(hcnt_q[5], lcnt_q[5], thr_q[11:0]));
	endproperty
	a_dec_update: assert property (p_dec_update)
		else $error("decoded level not updated at period end");

	property p_static_rb;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!fmt_w[0])[*3] |-> rb_q[0] == {1'b0, $past(io_pin_i[0], 2)};
	endproperty
	a_static_rb: assert property (p_static_rb)
		else $error("static readback wrong");

	property p_bus_answer;
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == gpp_pkg::GPP_IDLE && (avs_read_i || avs_write_i)) |=>
			!avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not one cycle wide");

	c_pwm_out: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		fmt_w[0] && pend_w[0] && sel_q[0]);
	c_decode3: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		fmt_w[5] && rb_q[5] == 2'h3);
	c_special: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		io_cfg_q[gpp_pkg::POS_SRC+3] && io_pin_oe_o[3]);
endmodule

// File: tb/gpp_pin_model.sv
/*
 * gpp_pin_model: the circuits that sit on the nine pins. A pin that the
 * device drives reads back its own level; any other pin gets a static
 * level or the shared pwm wave, as the bench selects.
 * Assumes the bench keeps lo_units_i + hi_units_i above zero.
 */
`timescale 1ns/1ps
module gpp_pin_model #(
	parameter int UNIT = 128
) (
	input wire logic clk_i,
	input wire logic [4:0] io_pin_o,
	input wire logic [4:0] io_pin_oe_o,
	input wire logic [3:0] ana_pin_o,
	input wire logic [3:0] ana_pin_oe_o,
	input wire logic [4:0] io_static_i,
	input wire logic [3:0] ana_static_i,
	input wire logic [4:0] io_pwm_i,
	input wire logic [3:0] ana_pwm_i,
	input wire logic [7:0] lo_units_i,
	input wire logic [7:0] hi_units_i,
	output logic [4:0] io_pin_i,
	output logic [3:0] ana_pin_i
);
	// ***********************************************************
	// pwm source
	// ***********************************************************
	int cnt_q = 0;
	int lo_q = 1;
	int hi_q = 1;
	logic wave;
	logic [4:0] io_ext;
	logic [3:0] ana_ext;

	// new duty only at a period start, so no period is ever torn
	always @(posedge clk_i) begin
		if (cnt_q + 1 >= (lo_q + hi_q) * UNIT) begin
			cnt_q <= 0;
			lo_q <= int'(lo_units_i);
			hi_q <= int'(hi_units_i);
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign wave = (cnt_q >= lo_q * UNIT); // low phase first

	// driven pins read back what the device drives
	assign io_ext = (io_pwm_i & {5{wave}}) | (~io_pwm_i & io_static_i);
	assign ana_ext = (ana_pwm_i & {4{wave}}) | (~ana_pwm_i & ana_static_i);
	assign io_pin_i = (io_pin_oe_o & io_pin_o) | (~io_pin_oe_o & io_ext);
	assign ana_pin_i = (ana_pin_oe_o & ana_pin_o) | (~ana_pin_oe_o & ana_ext);
endmodule

// File: tb/tb_gpp_top.sv
/*
 * tb_gpp_top: register-level tests of the pin block through Avalon-MM.
 * Assumes the pin model loops driven pins back and makes pwm in units
 * of 128 clocks, equal to time base setting 0.
 */
`timescale 1ns/1ps
module tb_gpp_top;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic fault_i = 1'b0;
	logic status_i = 1'b0;
	logic occ_a_i = 1'b0;
	logic occ_b_i = 1'b0;
	logic [4:0] io_pin_i, io_pin_o, io_pin_oe_o;
	logic [3:0] ana_pin_i, ana_pin_o, ana_pin_oe_o;
	logic [4:0] io_static = 5'h00;
	logic [4:0] io_pwm = 5'h00;
	logic [3:0] ana_static = 4'h0;
	logic [3:0] ana_pwm = 4'h0;
	logic [7:0] lo_u = 8'h06;
	logic [7:0] hi_u = 8'h02;
	logic [31:0] rv;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	// ***********************************************************
	// clock, design, pins
	// ***********************************************************
	always #50 clk_i = ~clk_i;

	gpp_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .fault_i(fault_i),
		.status_i(status_i), .occ_a_i(occ_a_i), .occ_b_i(occ_b_i),
		.io_pin_i(io_pin_i), .io_pin_o(io_pin_o),
		.io_pin_oe_o(io_pin_oe_o), .ana_pin_i(ana_pin_i),
		.ana_pin_o(ana_pin_o), .ana_pin_oe_o(ana_pin_oe_o));

	gpp_pin_model part_u (.clk_i(clk_i), .io_pin_o(io_pin_o),
		.io_pin_oe_o(io_pin_oe_o), .ana_pin_o(ana_pin_o),
		.ana_pin_oe_o(ana_pin_oe_o), .io_static_i(io_static),
		.ana_static_i(ana_static), .io_pwm_i(io_pwm),
		.ana_pwm_i(ana_pwm), .lo_units_i(lo_u), .hi_units_i(hi_u),
		.io_pin_i(io_pin_i), .ana_pin_i(ana_pin_i));

	// ***********************************************************
	// tasks
	// ***********************************************************
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one access; held until waitrequest is sampled low
	task automatic bus(input logic [5:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		avs_address_i <= a;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_writedata_i <= d;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0 && k < 50) begin
			@(posedge clk_i);
			k++;
		end
		q = avs_readdata_o;
		if (k >= 50) failures++;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		// one idle edge, so no signal is set twice in a time step
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, rv);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0, rv);
		chk(rv, exp);
	endtask

	// waits for pin p to reach lvl, then counts clocks it stays there
	task automatic phase(input int p, input logic lvl, output int len);
		int k;
		k = 0;
		len = 0;
		while (io_pin_o[p] !== lvl && k < 5000) begin
			@(posedge clk_i);
			k++;
		end
		while (io_pin_o[p] === lvl && len < 5000) begin
			@(posedge clk_i);
			len++;
		end
	endtask

	// hang guard: well above the ~15000 cycles the tests need
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			failures++;
			close_out();
		end
	end

	// ***********************************************************
	// tests
	// ***********************************************************
	initial begin
		repeat (16) @(posedge clk_i);
		chk({23'h0, io_pin_oe_o, ana_pin_oe_o}, 32'h0);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rdc(gpp_pkg::OFS_THR, gpp_pkg::RST_THR);
		rdc(6'h3C, 32'h0);
		$display("test reset finished");

		// static io outputs and readback
		wr(gpp_pkg::OFS_IO_CFG, 32'h1600001F);
		repeat (2) @(posedge clk_i);
		chk({27'h0, io_pin_oe_o}, 32'h1F);
		chk({27'h0, io_pin_o}, 32'h16);
		rdc(gpp_pkg::OFS_IO_RB, 32'h114);
		io_static <= 5'h0A;
		wr(gpp_pkg::OFS_IO_CFG, 32'h1F000005);
		repeat (2) @(posedge clk_i);
		chk({27'h0, io_pin_oe_o}, 32'h05);
		rdc(gpp_pkg::OFS_IO_RB, 32'h055);
		$display("test static finished");

		// special sources override the level bit
		fault_i <= 1'b1;
		occ_a_i <= 1'b1;
		wr(gpp_pkg::OFS_IO_CFG, 32'h000F000F);
		repeat (4) @(posedge clk_i);
		chk({28'h0, io_pin_o[3:0]}, 32'h5);
		fault_i <= 1'b0;
		status_i <= 1'b1;
		occ_a_i <= 1'b0;
		occ_b_i <= 1'b1;
		wr(gpp_pkg::OFS_IO_CFG, 32'h1F0F000F);
		repeat (4) @(posedge clk_i);
		chk({28'h0, io_pin_o[3:0]}, 32'hA);
		$display("test special finished");

		// analog pins: static out even with the format bit set
		// static readback first: with the format bit set the pins decode
		wr(gpp_pkg::OFS_ANA_CFG, 32'h000A000F);
		repeat (2) @(posedge clk_i);
		chk({28'h0, ana_pin_oe_o}, 32'hF);
		chk({28'h0, ana_pin_o}, 32'hA);
		rdc(gpp_pkg::OFS_ANA_RB, 32'h44);
		wr(gpp_pkg::OFS_ANA_CFG, 32'h000A0F0F);
		repeat (300) @(posedge clk_i);
		chk({28'h0, ana_pin_o}, 32'hA);
		$display("test analog finished");

		// reset in mid-run must turn every driven pin back to input
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({23'h0, io_pin_oe_o, ana_pin_oe_o}, 32'h0);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		$display("test mid reset finished");

		// pwm out on pin 0, base 128 clocks
		wr(gpp_pkg::OFS_IO_TB, 32'h0);
		wr(gpp_pkg::OFS_PWM0, 32'h03010102);
		wr(gpp_pkg::OFS_IO_CFG, 32'h00000101);
		phase(0, 1'b1, n);
		phase(0, 1'b0, n);
		chk(n, 256);
		phase(0, 1'b1, n);
		chk(n, 128);
		// level flips early in a low phase: that period must finish
		wr(gpp_pkg::OFS_IO_CFG, 32'h01000101);
		phase(0, 1'b0, n);
		chk(32'(n >= 240 && n <= 256), 32'h1);
		phase(0, 1'b1, n);
		chk(n, 128);
		phase(0, 1'b0, n);
		chk(n, 128);
		phase(0, 1'b1, n);
		chk(n, 384);
		wr(gpp_pkg::OFS_IO_TB, 32'h3);
		wr(gpp_pkg::OFS_PWM0, 32'h01010101);
		phase(0, 1'b1, n);
		phase(0, 1'b0, n);
		phase(0, 1'b1, n);
		chk(n, 1024);
		phase(0, 1'b0, n);
		chk(n, 1024);
		$display("test pwm out finished");

		// pwm decode on io pin 4 and analog pin 0, duty 2/8
		io_static <= 5'h00;
		io_pwm <= 5'h10;
		ana_pwm <= 4'h1;
		wr(gpp_pkg::OFS_IO_TB, 32'h0);
		wr(gpp_pkg::OFS_IO_CFG, 32'h00001000);
		wr(gpp_pkg::OFS_ANA_CFG, 32'h00000100);
		repeat (3200) @(posedge clk_i);
		rdc(gpp_pkg::OFS_IO_RB, 32'h100);
		rdc(gpp_pkg::OFS_ANA_RB, 32'h1);
		wr(gpp_pkg::OFS_THR, 32'h00000643);
		repeat (2300) @(posedge clk_i);
		rdc(gpp_pkg::OFS_IO_RB, 32'h0);
		// duty 6/8: source switches within one period, two more to settle
		lo_u <= 8'h02;
		hi_u <= 8'h06;
		repeat (3200) @(posedge clk_i);
		rdc(gpp_pkg::OFS_IO_RB, 32'h300);
		rdc(gpp_pkg::OFS_ANA_RB, 32'h3);
		$display("test pwm decode finished");
		close_out();
	end
endmodule
